// ==== src/mmc_regs.svh ====
// Register offsets, field positions, reset values and counts of the mode and map block
`ifndef MMC_REGS_SVH
`define MMC_REGS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define MMC_IDX_PRIORITY_AND_MODE 8'h3c
`define MMC_IDX_RAM_REGISTER_MAP 8'h3d
`define MMC_IDX_SYSTEM_CONFIGURATION 8'h3f
`define MMC_IDX_NV_PROGRAM 8'h40
`define MMC_IDX_LOCK_STATUS 8'h41

// ==========================================================
// Field positions
`define MMC_HP_BOOT_ROM 7
`define MMC_HP_SPECIAL 6
`define MMC_HP_MODE_A 5
`define MMC_CFG_UNUSED_BIT 6
`define MMC_NVP_ARM 0

// ==========================================================
// Reset values and the read mask of the unused configuration bit
`define MMC_PRIO_SEL_RESET 5'h06
`define MMC_MAP_RESET 8'h00
`define MMC_CFG_UNUSED_MASK 8'h40
`define MMC_NV_DEFAULT 8'hff

// ==========================================================
// Address ranges
`define MMC_BOOT_ROM_LO 16'hbe00
`define MMC_BOOT_ROM_HI 16'hbfff
`define MMC_ROM_LOW_BASE 16'h2000
`define MMC_ROM_LOW_END_SMALL 16'h7fff
`define MMC_ROM_LOW_END_LARGE 16'h9fff
`define MMC_ROM_HIGH_BASE_SMALL 16'ha000
`define MMC_ROM_HIGH_BASE_LARGE 16'h8000
`define MMC_ROM_HIGH_END 16'hffff

// ==========================================================
// Timing counts
`define MMC_MAP_WINDOW_CYCLES 7'h40
`define MMC_AUX_HALF_PERIOD 4

// ==========================================================
// Bus answers
`define MMC_RESP_OKAY 2'h0
`define MMC_RESP_SLVERR 2'h2

`endif

// ==== src/mmc_pkg.sv ====
// Types shared by the mode and memory map configuration block
package mmc_pkg;

    // ==========================================================
    // Start-up phase
    typedef enum logic [1:0] {
        PH_LOAD = 2'b01,
        PH_RUN = 2'b10
    } mmc_phase_t;

    // ==========================================================
    // Register layouts
    typedef struct packed {
        logic bootRomEnable;
        logic specialModeBit;
        logic modeABit;
        logic [4:0] prioSel;
    } mmc_prio_t;

    typedef struct packed {
        logic [3:0] ramNibble;
        logic [3:0] regNibble;
    } mmc_map_t;

    typedef struct packed {
        logic romPositionBit;
        logic unusedBit;
        logic clockOutputEnable;
        logic pullUpEnable;
        logic securityOff;
        logic watchdogOff;
        logic romEnableBit;
        logic eepromEnable;
    } mmc_cfg_t;

    // Registered address decode results
    typedef struct packed {
        logic bootRomHit;
        logic progRomHit;
        logic regBlockHit;
    } mmc_hit_t;

endpackage

// ==== src/mmc_nv_cell.sv ====
// Nonvolatile configuration byte: survives system reset, set to INIT_VALUE only at power-on
`timescale 1ns/1ps
`include "mmc_regs.svh"
module mmc_nv_cell #(
    parameter logic [7:0] INIT_VALUE = `MMC_NV_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic porRst_b,
    input wire logic wrEn,
    input wire logic [7:0] wrData,
    output logic [7:0] rdData
);

    logic [7:0] cell_q;

    // System reset does not touch the cell; that is what makes it nonvolatile
    always_ff @(posedge sys_clk or negedge porRst_b) begin
        if (!porRst_b) begin
            cell_q <= INIT_VALUE;
        end else if (wrEn) begin
            cell_q <= wrData;
        end
    end

    always_ff @(posedge sys_clk or negedge porRst_b) begin
        if (!porRst_b) begin
            rdData <= INIT_VALUE;
        end else begin
            rdData <= cell_q;
        end
    end

endmodule

// ==== src/mmc_config_top.sv ====
// Mode latch, RAM and register map, configuration latches behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "mmc_regs.svh"

module mmc_config_top #(
    parameter int ADDR_W = 12,
    parameter bit LARGE_ROM = 1'b0,
    parameter int AUX_HALF_PERIOD = `MMC_AUX_HALF_PERIOD,
    parameter logic [7:0] NV_INIT = `MMC_NV_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic porRst_b,
    input wire logic mode_pin_a,
    input wire logic mode_pin_b,
    input wire logic [15:0] cpuAddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output mmc_pkg::mmc_map_t memMap,
    output mmc_pkg::mmc_cfg_t sysCfg,
    output mmc_pkg::mmc_hit_t addrHit,
    output logic aux_clock_output_pin
);
    // ==========================================================
    // Elaboration checks
    if (ADDR_W < 10 || ADDR_W > 32) begin : gBadAddr
        $error("ADDR_W must lie between 10 and 32");
    end
    if (AUX_HALF_PERIOD < 1 || AUX_HALF_PERIOD > 255) begin : gBadDiv
        $error("AUX_HALF_PERIOD must lie between 1 and 255");
    end
    localparam logic [7:0] AUX_LAST = 8'(AUX_HALF_PERIOD - 1);
    function automatic logic regHit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        return (a[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (a[1:0] == 2'h0);
    endfunction
    function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo,
                                     input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction
    // ==========================================================
    // State
    mmc_pkg::mmc_phase_t phase_q;
    mmc_pkg::mmc_prio_t prio_q;
    mmc_pkg::mmc_map_t map_q;
    mmc_pkg::mmc_cfg_t cfg_q;
    logic modeALock_q;
    logic mapLock_q;
    logic [6:0] windowCnt_q;
    logic nvArm_q;
    logic awHeld_q;
    logic wHeld_q;
    logic [ADDR_W-1:0] awAddr_q;
    logic [7:0] wByte_q;
    logic wLane0_q;
    logic [7:0] auxCnt_q;
    logic auxPhase_q;
    logic [7:0] nvData;
    // ==========================================================
    // Mode decode from pins and start-up phase
    wire loadNow = (phase_q == mmc_pkg::PH_LOAD);
    wire pinSpecial = ~mode_pin_b;
    wire pinSingleChip = mode_pin_b & ~mode_pin_a;
    wire pinBootstrap = ~mode_pin_b & ~mode_pin_a;
    wire pinTest = ~mode_pin_b & mode_pin_a;
    wire special = prio_q.specialModeBit;
    wire windowOpen = (windowCnt_q < `MMC_MAP_WINDOW_CYCLES);
    // ==========================================================
    // Write decode
    wire doWrite = awHeld_q && wHeld_q && !bvalid;
    wire wrLane = doWrite && wLane0_q;
    wire hitPrioW = regHit(awAddr_q, `MMC_IDX_PRIORITY_AND_MODE);
    wire hitMapW = regHit(awAddr_q, `MMC_IDX_RAM_REGISTER_MAP);
    wire hitCfgW = regHit(awAddr_q, `MMC_IDX_SYSTEM_CONFIGURATION);
    wire hitNvpW = regHit(awAddr_q, `MMC_IDX_NV_PROGRAM);
    wire hitStsW = regHit(awAddr_q, `MMC_IDX_LOCK_STATUS);
    wire wrMapped = hitPrioW | hitMapW | hitCfgW | hitNvpW | hitStsW;
    wire wrPrio = wrLane && hitPrioW;
    wire wrModeA = wrPrio && (special || !modeALock_q);
    wire wrMap = wrLane && hitMapW && (special || (!mapLock_q && windowOpen));
    wire wrCfgLatch = wrLane && hitCfgW && special;
    // Normal mode reaches only the nonvolatile byte, and only when armed
    wire wrNv = wrLane && hitCfgW && (special || nvArm_q);
    // ==========================================================
    // Read decode
    wire hitPrioR = regHit(araddr, `MMC_IDX_PRIORITY_AND_MODE);
    wire hitMapR = regHit(araddr, `MMC_IDX_RAM_REGISTER_MAP);
    wire hitCfgR = regHit(araddr, `MMC_IDX_SYSTEM_CONFIGURATION);
    wire hitNvpR = regHit(araddr, `MMC_IDX_NV_PROGRAM);
    wire hitStsR = regHit(araddr, `MMC_IDX_LOCK_STATUS);
    wire rdMapped = hitPrioR | hitMapR | hitCfgR | hitNvpR | hitStsR;
    wire [7:0] cfgRead = cfg_q | `MMC_CFG_UNUSED_MASK;
    wire [7:0] stsRead = {5'h00, windowOpen, mapLock_q, modeALock_q};
    wire [7:0] rdByte = hitPrioR ? prio_q :
                        hitMapR ? map_q :
                        hitCfgR ? cfgRead :
                        hitNvpR ? {7'h00, nvArm_q} :
                        hitStsR ? stsRead : 8'h00;
    // ==========================================================
    // Load value for the configuration latches
    mmc_pkg::mmc_cfg_t cfgLoad;
    always_comb begin
        cfgLoad = mmc_pkg::mmc_cfg_t'(nvData);
        if (pinSingleChip) begin
            cfgLoad.romPositionBit = 1'b1;
            cfgLoad.romEnableBit = 1'b1;
        end
        if (pinTest) begin
            cfgLoad.romEnableBit = 1'b0;
        end
    end
    // ==========================================================
    // Address decode
    wire [15:0] romLowEnd = LARGE_ROM ? `MMC_ROM_LOW_END_LARGE : `MMC_ROM_LOW_END_SMALL;
    wire [15:0] romHighBase = LARGE_ROM ? `MMC_ROM_HIGH_BASE_LARGE : `MMC_ROM_HIGH_BASE_SMALL;
    wire bootHitNext = prio_q.bootRomEnable && special &&
                       inRange(cpuAddr, `MMC_BOOT_ROM_LO, `MMC_BOOT_ROM_HI);
    wire romRangeHit = cfg_q.romPositionBit ?
                       inRange(cpuAddr, romHighBase, `MMC_ROM_HIGH_END) :
                       inRange(cpuAddr, `MMC_ROM_LOW_BASE, romLowEnd);
    wire romHitNext = cfg_q.romEnableBit && romRangeHit;
    wire regBlkNext = (cpuAddr[15:12] == map_q.regNibble) && (cpuAddr[11:7] == 5'h00);
    wire auxTick = (auxCnt_q == AUX_LAST);
    // ==========================================================
    // Nonvolatile configuration byte
    mmc_nv_cell #(
        .INIT_VALUE(NV_INIT)
    ) uNvCell (
        .sys_clk(sys_clk),
        .porRst_b(porRst_b),
        .wrEn(wrNv),
        .wrData(wByte_q),
        .rdData(nvData)
    );
    // ==========================================================
    // Start-up phase: one cycle to catch straps and cells after release
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= mmc_pkg::PH_LOAD;
        end else begin
            case (phase_q)
                mmc_pkg::PH_LOAD: phase_q <= mmc_pkg::PH_RUN;
                mmc_pkg::PH_RUN: phase_q <= mmc_pkg::PH_RUN;
                default: phase_q <= mmc_pkg::PH_LOAD;
            endcase
        end
    end

    // ==========================================================
    // Priority and mode register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prio_q <= {3'h0, `MMC_PRIO_SEL_RESET};
            modeALock_q <= 1'b0;
        end else if (loadNow) begin
            prio_q.bootRomEnable <= pinBootstrap;
            prio_q.specialModeBit <= pinSpecial;
            prio_q.modeABit <= mode_pin_a;
        end else if (wrPrio) begin
            prio_q.prioSel <= wByte_q[4:0];
            // A write can only clear the special bit
            prio_q.specialModeBit <= special & wByte_q[`MMC_HP_SPECIAL];
            if (special) begin
                prio_q.bootRomEnable <= wByte_q[`MMC_HP_BOOT_ROM];
            end
            if (wrModeA) begin
                prio_q.modeABit <= wByte_q[`MMC_HP_MODE_A];
                modeALock_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // RAM and register map with its write window
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            map_q <= `MMC_MAP_RESET;
            mapLock_q <= 1'b0;
            windowCnt_q <= 7'h00;
        end else begin
            if (windowOpen) begin
                windowCnt_q <= windowCnt_q + 7'h01;
            end
            if (wrMap) begin
                map_q <= wByte_q;
                mapLock_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Configuration latches and programming arm
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= 8'hff;
            nvArm_q <= 1'b0;
        end else if (loadNow) begin
            cfg_q <= cfgLoad;
            nvArm_q <= 1'b0;
        end else begin
            if (wrCfgLatch) begin
                cfg_q <= wByte_q;
            end
            if (wrLane && hitNvpW) begin
                nvArm_q <= wByte_q[`MMC_NVP_ARM];
            end else if (wrNv) begin
                nvArm_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // AXI4-Lite write channel
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            awready <= 1'b0;
            wready <= 1'b0;
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= '0;
            wByte_q <= 8'h00;
            wLane0_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `MMC_RESP_OKAY;
        end else begin
            if (loadNow) begin
                awready <= 1'b1;
                wready <= 1'b1;
            end
            if (awvalid && awready) begin
                awready <= 1'b0;
                awHeld_q <= 1'b1;
                awAddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                wHeld_q <= 1'b1;
                wByte_q <= wdata[7:0];
                wLane0_q <= wstrb[0];
            end
            if (doWrite) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wrMapped ? `MMC_RESP_OKAY : `MMC_RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // AXI4-Lite read channel
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `MMC_RESP_OKAY;
        end else begin
            if (loadNow) begin
                arready <= 1'b1;
            end
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= {24'h00_0000, rdByte};
                rresp <= rdMapped ? `MMC_RESP_OKAY : `MMC_RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Decode outputs and auxiliary clock
    // Registered decode costs one cycle of latency but keeps outputs glitch free
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            addrHit <= 3'h0;
            auxCnt_q <= 8'h00;
            auxPhase_q <= 1'b0;
            aux_clock_output_pin <= 1'b0;
        end else begin
            addrHit.bootRomHit <= bootHitNext;
            addrHit.progRomHit <= romHitNext;
            addrHit.regBlockHit <= regBlkNext;
            auxCnt_q <= auxTick ? 8'h00 : auxCnt_q + 8'h01;
            if (auxTick) begin
                auxPhase_q <= ~auxPhase_q;
            end
            aux_clock_output_pin <= cfg_q.clockOutputEnable & auxPhase_q;
        end
    end

    assign memMap = map_q;
    assign sysCfg = cfg_q;
endmodule

// ==== sim/mmc_config_checker.sv ====
// Port-level assertions for the mode and memory map configuration block
`timescale 1ns/1ps
module mmc_config_checker #(
    parameter int ADDR_W = 12,
    parameter bit LARGE_ROM = 1'b0,
    parameter int AUX_HALF_PERIOD = 4,
    parameter logic [7:0] NV_INIT = 8'hff
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [15:0] cpuAddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic bvalid,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire mmc_pkg::mmc_map_t memMap,
    input wire mmc_pkg::mmc_cfg_t sysCfg,
    input wire mmc_pkg::mmc_hit_t addrHit,
    input wire logic aux_clock_output_pin
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // Addresses of the transfers in flight
    logic [ADDR_W-1:0] rdAddr_q;
    logic [ADDR_W-1:0] wrAddr_q;
    logic wrMapped;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdAddr_q <= '0;
            wrAddr_q <= '0;
        end else begin
            if (arvalid && arready) rdAddr_q <= araddr;
            if (awvalid && awready) wrAddr_q <= awaddr;
        end
    end
    assign wrMapped = wrAddr_q inside {12'h0f0, 12'h0f4, 12'h0fc, 12'h100, 12'h104};
    // ==========================================================
    // Properties
    boot_window_a: assert property (
        addrHit.bootRomHit |-> $past(cpuAddr) >= 16'hbe00 && $past(cpuAddr) <= 16'hbfff)
        else $error("boot ROM hit outside its range");
    reg_block_a: assert property (
        rst_b |=> addrHit.regBlockHit == ($past(cpuAddr[15:12]) == $past(memMap.regNibble)
            && $past(cpuAddr[11:7]) == 5'h00))
        else $error("register block decode wrong");
    prog_rom_a: assert property (
        addrHit.progRomHit |-> $past(sysCfg.romEnableBit) && ($past(sysCfg.romPositionBit) ?
            $past(cpuAddr) >= (LARGE_ROM ? 16'h8000 : 16'ha000) :
            $past(cpuAddr) inside {[16'h2000:(LARGE_ROM ? 16'h9fff : 16'h7fff)]}))
        else $error("program ROM hit outside its range");
    aux_idle_a: assert property (
        !sysCfg.clockOutputEnable [*3] |-> !aux_clock_output_pin)
        else $error("aux clock pin active while disabled");
    aux_period_a: assert property (
        sysCfg.clockOutputEnable [*8] |-> aux_clock_output_pin != $past(aux_clock_output_pin, 4))
        else $error("aux clock pin not toggling every four cycles");
    cfg_read_a: assert property (
        rvalid && rdAddr_q == 12'h0fc |-> rdata == {24'h0, sysCfg | 8'h40})
        else $error("configuration read differs from latches");
    map_change_a: assert property (
        $changed(memMap) |-> $rose(bvalid) && wrAddr_q == 12'h0f4)
        else $error("map register changed without a write");
    cfg_change_a: assert property (
        $changed(sysCfg) |-> $past(rst_b, 2) == 1'b0 || ($rose(bvalid) && wrAddr_q == 12'h0fc))
        else $error("configuration latches changed outside load or write");
    bresp_code_a: assert property (
        bvalid |-> bresp == (wrMapped ? 2'h0 : 2'h2))
        else $error("write response code wrong");
endmodule

bind mmc_config_top mmc_config_checker #(.ADDR_W(ADDR_W), .LARGE_ROM(LARGE_ROM),
    .AUX_HALF_PERIOD(AUX_HALF_PERIOD), .NV_INIT(NV_INIT)) chk (.sys_clk, .rst_b, .cpuAddr,
    .awvalid, .awready, .awaddr, .bvalid, .bresp, .arvalid, .arready, .araddr, .rvalid, .rdata,
    .memMap, .sysCfg, .addrHit, .aux_clock_output_pin);

// ==== sim/mmc_config_top_tb_top.sv ====
// Self-checking bench for the mode and memory map configuration block
`timescale 1ns/1ps
module mmc_config_top_tb_top;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic porRst_b = 1'b0;
    logic mode_pin_a = 1'b1;
    logic mode_pin_b = 1'b1;
    logic [15:0] cpuAddr = 16'h0000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, auxPin;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    mmc_pkg::mmc_map_t memMap;
    mmc_pkg::mmc_cfg_t sysCfg;
    mmc_pkg::mmc_hit_t addrHit;
    logic [1:0] expB[$];
    logic [33:0] expR[$];
    int n_errors = 0;
    int checked = 0;
    logic [15:0] seed = 16'h003e;

    mmc_config_top dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .porRst_b(porRst_b), .mode_pin_a(mode_pin_a),
        .mode_pin_b(mode_pin_b), .cpuAddr(cpuAddr), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(4'h1), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .memMap(memMap), .sysCfg(sysCfg), .addrHit(addrHit),
        .aux_clock_output_pin(auxPin)
    );

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // Checking and closing
    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic timeout();
        n_errors++;
        $display("unexpected bus wait: expected an answer, seen none");
        tally_and_finish();
    endtask

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // ==========================================================
    // Stimulus tasks
    task automatic do_reset(input logic [1:0] pins);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        {mode_pin_b, mode_pin_a} <= pins;
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        porRst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask

    // Random decode traffic keeps the address assertions busy
    task automatic idle(input int k);
        repeat (k) begin
            seed = lfsr_next(seed);
            cpuAddr <= seed;
            @(posedge sys_clk);
        end
    endtask

    task automatic probe(input logic [15:0] a, input logic [2:0] exp);
        @(posedge sys_clk);
        cpuAddr <= a;
        repeat (2) @(posedge sys_clk);
        check("addrHit", 34'(addrHit), 34'(exp));
    endtask

    task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge sys_clk);
        expB.push_back(r);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) bready <= 1'b0;
            n++;
            if (n > 50) timeout();
        end while (!bvalid);
    endtask

    task automatic axi_read(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge sys_clk);
        expR.push_back({r, 24'h0, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) rready <= 1'b0;
            n++;
            if (n > 50) timeout();
        end while (!rvalid);
    endtask

    // Answers are taken off the queues as they appear
    always @(posedge sys_clk) begin
        if (bvalid && bready) check("bresp", 34'(bresp), 34'(expB.pop_front()));
        if (rvalid && rready) check("read", {rresp, rdata}, expR.pop_front());
    end

    // Single chip, expanded, bootstrap, special test
    task automatic mode_pass(input logic [7:0] cfg[4], input logic [2:0] hit[4]);
        logic [1:0] pins[4] = '{2'b10, 2'b11, 2'b00, 2'b01};
        logic [7:0] prio[4] = '{8'h06, 8'h26, 8'hc6, 8'h66};
        for (int m = 0; m < 4; m++) begin
            do_reset(pins[m]);
            check("sysCfg", 34'(sysCfg), 34'(cfg[m]));
            check("memMap", 34'(memMap), 34'(8'h00));
            axi_read(12'h0f0, prio[m], 2'h0);
            axi_read(12'h0fc, cfg[m] | 8'h40, 2'h0);
            probe(16'hbfff, hit[m]);
        end
        $display("test mode pass done");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        int cnt;
        logic last;
        mode_pass('{8'hff, 8'hff, 8'hff, 8'hfd}, '{3'b010, 3'b010, 3'b110, 3'b000});
        do_reset(2'b11);
        axi_read(12'h104, 8'h04, 2'h0);
        axi_write(12'h0f0, 8'hc6, 2'h0);
        axi_write(12'h0f0, 8'h26, 2'h0);
        axi_read(12'h0f0, 8'h06, 2'h0);
        axi_write(12'h0f4, 8'h5a, 2'h0);
        axi_write(12'h0f4, 8'h33, 2'h0);
        axi_read(12'h0f4, 8'h5a, 2'h0);
        probe(16'ha07f, 3'b011);
        probe(16'ha080, 3'b010);
        axi_write(12'h0fc, 8'h00, 2'h0);
        axi_write(12'h100, 8'h01, 2'h0);
        axi_write(12'h0fc, 8'hdf, 2'h0);
        axi_read(12'h0fc, 8'hff, 2'h0);
        axi_write(12'h0f8, 8'h55, 2'h2);
        axi_read(12'h0f8, 8'h00, 2'h2);
        idle(70);
        axi_read(12'h104, 8'h03, 2'h0);
        do_reset(2'b11);
        check("sysCfg", 34'(sysCfg), 34'(8'hdf));
        idle(70);
        axi_write(12'h0f4, 8'h77, 2'h0);
        check("memMap", 34'(memMap), 34'(8'h00));
        $display("test normal mode done");
        do_reset(2'b00);
        axi_write(12'h0f0, 8'h66, 2'h0);
        axi_read(12'h0f0, 8'h66, 2'h0);
        probe(16'hbe00, 3'b010);
        axi_write(12'h0f0, 8'he6, 2'h0);
        probe(16'hbe00, 3'b110);
        probe(16'hc000, 3'b010);
        axi_write(12'h0f4, 8'h12, 2'h0);
        idle(70);
        axi_write(12'h0f4, 8'h34, 2'h0);
        axi_read(12'h0f4, 8'h34, 2'h0);
        axi_write(12'h0fc, 8'h23, 2'h0);
        check("sysCfg", 34'(sysCfg), 34'(8'h23));
        axi_read(12'h0fc, 8'h63, 2'h0);
        probe(16'h2000, 3'b010);
        probe(16'h1fff, 3'b000);
        probe(16'h7fff, 3'b010);
        probe(16'h8000, 3'b000);
        cnt = 0;
        last = auxPin;
        repeat (16) begin
            @(posedge sys_clk);
            if (auxPin !== last) cnt++;
            last = auxPin;
        end
        check("aux toggles", 34'(cnt), 34'(4));
        axi_write(12'h0fc, 8'h00, 2'h0);
        axi_write(12'h0f0, 8'h26, 2'h0);
        axi_write(12'h0f0, 8'he6, 2'h0);
        axi_read(12'h0f0, 8'h26, 2'h0);
        $display("test special mode done");
        mode_pass('{8'h82, 8'h00, 8'h00, 8'h00}, '{3'b010, 3'b000, 3'b100, 3'b000});
        tally_and_finish();
    end
endmodule
